// ==== shpc_host_model.sv ====
`timescale 1ns/1ps
module shpc_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line,
  input  wire logic so_line
);
  // ----------------------------------------
  // Bus host, 64 ns bit time
  // ----------------------------------------
  // Clock starts high and stands high between I2C frames; SPI parks it low
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start_cond;
    sda_low = 1'b1;
    #32 scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    #8 sda_low = 1'b1;
    #24 scl = 1'b1;
    #32 sda_low = 1'b0;
    #32;
  endtask : stop_cond

  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #8 sda_low = !b[i];
      #24 scl = 1'b1;
      #32 scl = 1'b0;
    end
    #8 sda_low = 1'b0;
    #24 scl = 1'b1;
    #16 ack = !sda_line;
    #16 scl = 1'b0;
  endtask : wbyte

  task automatic rbyte(output logic [7:0] b, input logic last);
    for (int i = 0; i < 8; i++) begin
      #8 sda_low = 1'b0;
      #24 scl = 1'b1;
      #16 b = {b[6:0], sda_line};
      #16 scl = 1'b0;
    end
    #8 sda_low = !last;
    #24 scl = 1'b1;
    #32 scl = 1'b0;
  endtask : rbyte

  task automatic park_clock(input logic level);
    scl = level;
  endtask : park_clock

  // Mode 0: data set while clock low, both sides sample on the rise
  task automatic spi_byte(input logic [7:0] b, output logic [7:0] r, input logic three);
    for (int i = 7; i >= 0; i--) begin
      #8 sda_low = !b[i];
      #24 scl = 1'b1;
      #16 r = {r[6:0], three ? sda_line : so_line};
      #16 scl = 1'b0;
    end
  endtask : spi_byte
endmodule : shpc_host_model

// ==== shpc_pkg.sv ====
package shpc_pkg;

  typedef enum logic [2:0] {
    SHPC_IDLE,
    SHPC_RX,
    SHPC_ACK,
    SHPC_TX,
    SHPC_MACK
  } shpc_state_e;

  typedef struct packed {
    shpc_state_e  st;
    logic         scl_q;
    logic         sda_q;
    logic         csn_q;
    logic [3:0]   cnt;
    logic [7:0]   sr;
    logic [1:0]   phase;
    logic         rw;
    logic         mack;
    logic [7:0]   ptr;
    logic [7:0]   page;
    logic [6:0]   tgt;
    logic         line_mode;
    logic         io_sel;
    logic         tmo_ind;
    logic         tmo_flg;
    logic [22:0]  tcnt;
    logic         sda_out;
    logic         sda_oe;
    logic         so_out;
    logic         so_oe;
    logic [2:0]   cmd;
    logic [1:0]   sidx;
    logic         rd_act;
  } shpc_state_s;

endpackage : shpc_pkg

// ==== shpc_port.sv ====
// Behaviour
// - Interface type pin level picks I2C or SPI, never a register.
// - Serial data enters on the shared data pin in every mode.
// - Voltage and wire-count changes act at once, no wait needed.
// - Voltage select is one bit, 0 is 1.8 V default, 1 is 3.3 V.
// - Wire-count bit 0 gives 4-wire SPI default, 1 gives 3-wire SPI.
// - Target address setting sits in a 7-bit register field.
// - In I2C mode the device is slave only with 7-bit addressing.
// - I2C slave works at 100 kbps and 400 kbps.
// - Burst transfers advance the register address after each data byte.
// - Address is fixed five bits plus two address pick pins.
// - SCL low timeout detected and reported by indicator and flag.
// - Timeout indicator reads 1 while a timeout has occurred, else 0.
// - Sticky flag holds until written 0 with indicator no longer set.
// - Serial data moves MSB first in 8-bit words.
`timescale 1ns/1ps
`include "shpc_regs.svh"
module shpc_port #(
  parameter int TIMEOUT_CYC = `SHPC_TMO_CYC
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic i2c_mode_sel,
  input  wire logic scl_sclk,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic addr_pick_upper_pin,
  input  wire logic addr_pick_lower_pin,
  output logic      serial_out_pin,
  output logic      serial_out_oe,
  output logic      io_voltage_level_select,
  output logic      spi_line_mode,
  output logic      bus_timeout_indicator,
  output logic      bus_timeout_sticky_flag
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pins_s;
  logic       mode_i2c;
  logic       scl;
  logic       sda;
  logic       a1;
  logic       chip_select_n;

  shpc_sync #(.W(5)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({i2c_mode_sel, scl_sclk, sda_in, addr_pick_upper_pin, addr_pick_lower_pin}),
    .q       (pins_s)
  );

  assign mode_i2c      = pins_s[4];
  assign scl           = pins_s[3];
  assign sda           = pins_s[2];
  assign a1            = pins_s[1];
  assign chip_select_n = pins_s[0];  // Doubles as the lower address pick pin

  shpc_pkg::shpc_state_s s_reg;
  shpc_pkg::shpc_state_s s_next;

  // ------------------------------------------------------------
  // Next state and register read decode
  // ------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input shpc_pkg::shpc_state_s s, input logic [7:0] ofs);
    logic [15:0] a;
    logic [7:0]  v;
    a = {s.page, ofs};
    v = 8'h00;
    if (ofs == `SHPC_PAGE_OFS) v = s.page;
    else if (a == `SHPC_TGT_ADDR_ADR) v = {1'b0, s.tgt};
    else if (a == `SHPC_TMO_IND_ADR) v[`SHPC_TMO_BIT] = s.tmo_ind;
    else if (a == `SHPC_TMO_FLG_ADR) v[`SHPC_TMO_BIT] = s.tmo_flg;
    else if (a == `SHPC_LINE_MODE_ADR) v[`SHPC_LINE_MODE_BIT] = s.line_mode;
    else if (a == `SHPC_IO_SEL_ADR) v[`SHPC_IO_SEL_BIT] = s.io_sel;
    return v;
  endfunction : rd_byte

  always_comb begin
    logic        rise, fall, start, stop, we;
    logic [7:0]  wofs, wd, byte_in, d;
    logic [15:0] wa;
    s_next  = s_reg;
    we      = 1'b0;
    wofs    = 8'h00;
    wd      = 8'h00;
    d       = 8'h00;
    wa      = 16'h0000;
    rise    = scl & ~s_reg.scl_q;  // Many clocks per bit at either rate
    fall    = ~scl & s_reg.scl_q;
    start   = scl & s_reg.scl_q & s_reg.sda_q & ~sda;
    stop    = scl & s_reg.scl_q & ~s_reg.sda_q & sda;
    byte_in = {s_reg.sr[6:0], sda};
    s_next.scl_q = scl;
    s_next.sda_q = sda;
    s_next.csn_q = chip_select_n;

    if (mode_i2c) begin
      s_next.so_oe = 1'b0;
      s_next.sda_out = 1'b0;  // Open drain: only ever pull low
      // Timeout: clock held low inside a transaction
      s_next.tcnt = (s_reg.st != shpc_pkg::SHPC_IDLE && !scl) ? s_reg.tcnt + 23'd1 : '0;
      if (start) begin
        s_next.st      = shpc_pkg::SHPC_RX;
        s_next.phase   = 2'd0;
        s_next.cnt     = 4'd0;
        s_next.sda_oe  = 1'b0;
        s_next.tmo_ind = 1'b0;
        s_next.tcnt    = '0;
      end else if (stop) begin
        s_next.st     = shpc_pkg::SHPC_IDLE;
        s_next.sda_oe = 1'b0;
      end else if (s_reg.tcnt >= TIMEOUT_CYC[22:0] - 23'd1 && s_reg.st != shpc_pkg::SHPC_IDLE && !scl) begin
        s_next.tmo_ind = 1'b1;
        s_next.st      = shpc_pkg::SHPC_IDLE;
        s_next.sda_oe  = 1'b0;
        s_next.tcnt    = '0;
      end else begin
        case (s_reg.st)
          shpc_pkg::SHPC_RX: begin
            if (rise && s_reg.cnt != 4'd8) begin
              s_next.sr  = byte_in;
              s_next.cnt = s_reg.cnt + 4'd1;
            end else if (fall && s_reg.cnt == 4'd8) begin
              s_next.cnt    = 4'd0;
              s_next.st     = shpc_pkg::SHPC_ACK;
              s_next.sda_oe = 1'b1;
              case (s_reg.phase)
                2'd0: begin
                  // Slave only, 7-bit address match
                  if (s_reg.sr[7:1] == {s_reg.tgt[6:2], a1, chip_select_n}) begin
                    s_next.rw    = s_reg.sr[0];
                    s_next.phase = 2'd1;
                  end else begin
                    s_next.st     = shpc_pkg::SHPC_IDLE;
                    s_next.sda_oe = 1'b0;
                  end
                end
                2'd1: begin
                  s_next.ptr   = s_reg.sr;
                  s_next.phase = 2'd2;
                end
                default: begin
                  we          = 1'b1;
                  wofs        = s_reg.ptr;
                  wd          = s_reg.sr;
                  s_next.ptr  = s_reg.ptr + 8'd1;
                end
              endcase
            end
          end
          shpc_pkg::SHPC_ACK: begin
            if (fall) begin
              if (s_reg.rw) begin
                d             = rd_byte(s_reg, s_reg.ptr);
                s_next.sda_oe = ~d[7];
                s_next.sr     = {d[6:0], 1'b0};
                s_next.ptr    = s_reg.ptr + 8'd1;
                s_next.st     = shpc_pkg::SHPC_TX;
              end else begin
                s_next.sda_oe = 1'b0;
                s_next.st     = shpc_pkg::SHPC_RX;
              end
            end
          end
          shpc_pkg::SHPC_TX: begin
            if (rise) begin
              s_next.cnt = s_reg.cnt + 4'd1;
            end else if (fall) begin
              if (s_reg.cnt == 4'd8) begin
                s_next.sda_oe = 1'b0;
                s_next.cnt    = 4'd0;
                s_next.st     = shpc_pkg::SHPC_MACK;
              end else begin
                s_next.sda_oe = ~s_reg.sr[7];
                s_next.sr     = {s_reg.sr[6:0], 1'b0};
              end
            end
          end
          shpc_pkg::SHPC_MACK: begin
            if (rise) begin
              // Ack: next byte goes out at this clock's fall, nack ends the burst
              s_next.mack = ~sda;
              s_next.st   = sda ? shpc_pkg::SHPC_IDLE : shpc_pkg::SHPC_ACK;
            end
          end
          shpc_pkg::SHPC_IDLE: begin
            s_next.sda_oe = 1'b0;
          end
          default: begin
            s_next.st     = shpc_pkg::SHPC_IDLE;
            s_next.sda_oe = 1'b0;
          end
        endcase
      end
    end else begin
      // SPI, mode 0: sample on rise, shift out on fall
      s_next.st   = shpc_pkg::SHPC_IDLE;
      s_next.tcnt = '0;
      if (chip_select_n) begin
        s_next.cnt    = 4'd0;
        s_next.sidx   = 2'd0;
        s_next.rd_act = 1'b0;
        s_next.so_oe  = 1'b0;
        s_next.sda_oe = 1'b0;
      end else if (rise) begin
        if (!s_reg.rd_act) s_next.sr = byte_in;  // Read data shifts on fall only
        s_next.cnt = (s_reg.cnt == 4'd7) ? 4'd0 : s_reg.cnt + 4'd1;
        if (s_reg.cnt == 4'd7) begin
          s_next.rd_act = 1'b0;
          case (s_reg.sidx)
            2'd0: begin
              s_next.cmd  = byte_in[7:5];
              s_next.sidx = 2'd1;
              if (byte_in[7:5] == 3'b100 || byte_in[7:5] == 3'b101) begin
                s_next.rd_act = 1'b1;
                s_next.sr     = rd_byte(s_reg, s_reg.ptr);
                if (byte_in[5]) s_next.ptr = s_reg.ptr + 8'd1;
              end
            end
            2'd1: begin
              case (s_reg.cmd)
                3'b000, 3'b111: s_next.ptr = byte_in;
                3'b010, 3'b011: begin
                  we   = 1'b1;
                  wofs = s_reg.ptr;
                  wd   = byte_in;
                  if (s_reg.cmd[0]) s_next.ptr = s_reg.ptr + 8'd1;
                end
                default: s_next.ptr = s_reg.ptr;
              endcase
              if (s_reg.cmd == 3'b111) s_next.sidx = 2'd2;
              else s_next.sidx = 2'd3;
            end
            2'd2: begin
              we         = 1'b1;
              wofs       = s_reg.ptr;
              wd         = byte_in;
              s_next.ptr = s_reg.ptr + 8'd1;
            end
            default: s_next.sidx = 2'd3;
          endcase
        end
      end else if (fall) begin
        // Wire count read live so a change acts on the next bit
        s_next.so_out  = s_reg.sr[7];
        s_next.sda_out = s_reg.sr[7];
        s_next.so_oe   = s_reg.rd_act & ~s_reg.line_mode;
        s_next.sda_oe  = s_reg.rd_act & s_reg.line_mode;
        if (s_reg.rd_act) s_next.sr = {s_reg.sr[6:0], 1'b0};
      end
    end

    // Register write, shared by both protocols
    wa = {s_reg.page, wofs};
    if (we) begin
      if (wofs == `SHPC_PAGE_OFS) s_next.page = wd;
      else if (wa == `SHPC_TGT_ADDR_ADR) s_next.tgt = wd[6:0];
      else if (wa == `SHPC_LINE_MODE_ADR) s_next.line_mode = wd[`SHPC_LINE_MODE_BIT];
      else if (wa == `SHPC_IO_SEL_ADR) s_next.io_sel = wd[`SHPC_IO_SEL_BIT];
      else if (wa == `SHPC_TMO_FLG_ADR && !wd[`SHPC_TMO_BIT] && !s_reg.tmo_ind) s_next.tmo_flg = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (s_next.tmo_ind) s_next.tmo_flg = 1'b1;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg           <= '0;
      s_reg.st        <= shpc_pkg::SHPC_IDLE;
      // Edge history stays low like the synchronisers: a pin idling high shows one rise as they fill
      s_reg.page      <= `SHPC_PAGE_RST;
      s_reg.tgt       <= `SHPC_TGT_ADDR_RST;
      s_reg.line_mode <= `SHPC_LINE_MODE_RST;
      s_reg.io_sel    <= `SHPC_IO_SEL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sda_out                 = s_reg.sda_out;
  assign sda_oe                  = s_reg.sda_oe;
  assign serial_out_pin          = s_reg.so_out;
  assign serial_out_oe           = s_reg.so_oe;
  assign io_voltage_level_select = s_reg.io_sel;
  assign spi_line_mode           = s_reg.line_mode;
  assign bus_timeout_indicator   = s_reg.tmo_ind;
  assign bus_timeout_sticky_flag = s_reg.tmo_flg;

endmodule : shpc_port

// ==== shpc_port_assertions.sv ====
`timescale 1ns/1ps
module shpc_port_checker #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic i2c_mode_sel,
  input wire logic scl_sclk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_pick_upper_pin,
  input wire logic addr_pick_lower_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic io_voltage_level_select,
  input wire logic spi_line_mode,
  input wire logic bus_timeout_indicator,
  input wire logic bus_timeout_sticky_flag
);
  // ----------------------------------------
  // Helper counters on the raw pins
  // ----------------------------------------
  logic [31:0] low_cnt;
  logic [3:0]  start_age;
  logic        scl_q;
  logic        sda_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt   <= '0;
      start_age <= 4'hf;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
    end else begin
      low_cnt   <= scl_sclk ? '0 : low_cnt + 32'h1;
      scl_q     <= scl_sclk;
      sda_q     <= sda_in;
      if (scl_q && scl_sclk && sda_q && !sda_in)
        start_age <= 4'h0;
      else if (start_age != 4'hf)
        start_age <= start_age + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_timeout_held;
    bus_timeout_indicator [*2];
  endsequence

  a_release_on_tmo: assert property (s_timeout_held |-> !sda_oe)
    else $error("data line driven during timeout");
  a_tmo_needs_low: assert property ($rose(bus_timeout_indicator) |-> low_cnt >= TIMEOUT_CYC)
    else $error("timeout raised before clock low long enough");
  a_flag_follows: assert property ($rose(bus_timeout_indicator) |-> ##[0:1] bus_timeout_sticky_flag)
    else $error("sticky flag did not follow timeout");
  a_flag_sticks: assert property (bus_timeout_sticky_flag && bus_timeout_indicator |=> bus_timeout_sticky_flag)
    else $error("sticky flag dropped while indicator set");
  a_flag_cause: assert property ($rose(bus_timeout_sticky_flag) |-> bus_timeout_indicator)
    else $error("sticky flag set without timeout");
  a_ind_start_clear: assert property ($fell(bus_timeout_indicator) |-> start_age < 4'hf)
    else $error("indicator cleared without start");
  a_drive_on_low: assert property ($changed(sda_oe) |-> !scl_sclk)
    else $error("data drive changed while clock high");
  a_open_drain: assert property (i2c_mode_sel && sda_oe |-> !sda_out)
    else $error("data line driven high in serial bus mode");
  a_no_spi_out: assert property (i2c_mode_sel [*5] |-> !serial_out_oe)
    else $error("spi output driven in serial bus mode");
  a_mode_on_low: assert property (i2c_mode_sel && $changed(spi_line_mode) |-> !scl_sclk)
    else $error("wire count changed while clock high");
  a_out_four_wire: assert property (serial_out_oe |-> !spi_line_mode)
    else $error("data out pin driven in three wire mode");
  a_sdio_three_wire: assert property (!i2c_mode_sel && sda_oe |-> spi_line_mode)
    else $error("shared data pin driven in four wire mode");
endmodule : shpc_port_checker

bind shpc_port shpc_port_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk(clk), .reset_n(reset_n), .i2c_mode_sel(i2c_mode_sel), .scl_sclk(scl_sclk),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_pick_upper_pin(addr_pick_upper_pin), .addr_pick_lower_pin(addr_pick_lower_pin),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .io_voltage_level_select(io_voltage_level_select), .spi_line_mode(spi_line_mode),
  .bus_timeout_indicator(bus_timeout_indicator), .bus_timeout_sticky_flag(bus_timeout_sticky_flag));

// ==== shpc_regs.svh ====
`ifndef SHPC_REGS_SVH
`define SHPC_REGS_SVH

// ------------------------------------------------------------
// Register map (16-bit full address = {page, offset})
// ------------------------------------------------------------
`define SHPC_PAGE_OFS       8'h01
`define SHPC_TGT_ADDR_ADR   16'h000b
`define SHPC_TMO_IND_ADR    16'h000c
`define SHPC_TMO_FLG_ADR    16'h0011
`define SHPC_LINE_MODE_ADR  16'h002b
`define SHPC_IO_SEL_ADR     16'h0943

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define SHPC_TMO_BIT        5
`define SHPC_LINE_MODE_BIT  3
`define SHPC_IO_SEL_BIT     0
// Arbitrary default, upper five bits form the fixed part
`define SHPC_TGT_ADDR_RST   7'h54
`define SHPC_LINE_MODE_RST  1'b0
`define SHPC_IO_SEL_RST     1'b0
`define SHPC_PAGE_RST       8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SHPC_CLK_MHZ        200
`define SHPC_TMO_MS         25
`define SHPC_TMO_CYC        (`SHPC_TMO_MS * `SHPC_CLK_MHZ * 1000)
`define SHPC_TMO_W          23

`endif

// ==== shpc_sync.sv ====
`timescale 1ns/1ps
module shpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : shpc_sync

// ==== tb_serial_host_port_config.sv ====
`timescale 1ns/1ps
`include "shpc_regs.svh"
module tb_serial_host_port_config;
  localparam int         TMO  = 200;
  localparam logic [6:0] TGT  = `SHPC_TGT_ADDR_RST;
  localparam logic [6:0] ADDR = {TGT[6:2], 2'b10};
  logic clk, reset_n, i2c_mode_sel, pick_hi, pick_lo, scl, h_low, sda_line;
  logic sda_out, sda_oe, so_pin, so_oe, io_sel, line_mode, tmo_ind, tmo_flg, so_line;
  int   miscompares;
  int   comparisons;

  // Open drain with pull-up
  assign sda_line = !(h_low || (sda_oe && !sda_out));
  // Undriven data out shows the inverse, so a missing drive is caught
  assign so_line  = so_oe ? so_pin : !so_pin;

  shpc_port #(.TIMEOUT_CYC(TMO)) u_dut (
    .clk(clk), .reset_n(reset_n), .i2c_mode_sel(i2c_mode_sel), .scl_sclk(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_pick_upper_pin(pick_hi), .addr_pick_lower_pin(pick_lo),
    .serial_out_pin(so_pin), .serial_out_oe(so_oe),
    .io_voltage_level_select(io_sel), .spi_line_mode(line_mode),
    .bus_timeout_indicator(tmo_ind), .bus_timeout_sticky_flag(tmo_flg));
  shpc_host_model u_host (.scl(scl), .sda_low(h_low), .sda_line(sda_line), .so_line(so_line));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic i2c_wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d0,
                        input logic [7:0] d1, input logic two, input logic exp_ack);
    logic ack;
    u_host.start_cond();
    u_host.wbyte({a, 1'b0}, ack);
    chk({7'h00, ack}, {7'h00, exp_ack}, "address ack");
    if (ack) begin
      u_host.wbyte(r, ack);
      u_host.wbyte(d0, ack);
      if (two) u_host.wbyte(d1, ack);
    end
    u_host.stop_cond();
  endtask : i2c_wr

  task automatic i2c_rd2(input logic [7:0] r, output logic [7:0] d0, output logic [7:0] d1);
    logic ack;
    // Pointer set only: a data byte here would overwrite the register
    u_host.start_cond();
    u_host.wbyte({ADDR, 1'b0}, ack);
    u_host.wbyte(r, ack);
    u_host.stop_cond();
    u_host.start_cond();
    u_host.wbyte({ADDR, 1'b1}, ack);
    chk({7'h00, ack}, 8'h01, "read address ack");
    u_host.rbyte(d0, 1'b0);
    u_host.rbyte(d1, 1'b1);
    u_host.stop_cond();
  endtask : i2c_rd2

  task automatic spi_txn(input logic [23:0] bytes, input int n, input logic three,
                         output logic [7:0] rx);
    @(negedge clk) pick_lo = 1'b0;
    for (int k = n - 1; k >= 0; k--)
      u_host.spi_byte(bytes[8*k +: 8], rx, three);
    #32;
    @(negedge clk) pick_lo = 1'b1;
    repeat (4) @(negedge clk);
  endtask : spi_txn

  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #300000;
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic       ack;
    logic [7:0] d0;
    logic [7:0] d1;
    miscompares  = 0;
    comparisons  = 0;
    reset_n      = 1'b0;
    i2c_mode_sel = 1'b1;
    pick_hi      = 1'b1;
    pick_lo      = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    repeat (8) @(negedge clk);
    chk({6'h00, io_sel, line_mode}, 8'h00, "reset levels");
    chk({6'h00, tmo_ind, tmo_flg}, 8'h00, "reset timeout bits");
    // Mode pin low with select high: bus traffic must be ignored
    @(negedge clk) i2c_mode_sel = 1'b0;
    pick_lo = 1'b1;
    repeat (8) @(negedge clk);
    i2c_wr(ADDR, 8'h01, 8'h09, 8'h00, 1'b0, 1'b0);
    @(negedge clk) i2c_mode_sel = 1'b1;
    pick_lo = 1'b0;
    repeat (8) @(negedge clk);
    i2c_wr(ADDR ^ 7'h01, 8'h01, 8'h09, 8'h00, 1'b0, 1'b0);
    i2c_wr(ADDR, 8'h01, 8'h09, 8'h00, 1'b0, 1'b1);
    i2c_wr(ADDR, 8'h43, 8'h01, 8'h00, 1'b0, 1'b1);
    chk({7'h00, io_sel}, 8'h01, "voltage select");
    i2c_wr(ADDR, 8'h01, 8'h00, 8'h00, 1'b0, 1'b1);
    i2c_wr(ADDR, 8'h2a, 8'h00, 8'h08, 1'b1, 1'b1);
    chk({7'h00, line_mode}, 8'h01, "wire count select");
    i2c_rd2(8'h0b, d0, d1);
    chk(d0, {1'b0, TGT}, "target address read");
    chk(d1, 8'h00, "indicator read");
    // Clock parked low mid-frame
    u_host.start_cond();
    u_host.wbyte({ADDR, 1'b0}, ack);
    repeat (TMO + 60) @(negedge clk);
    chk({6'h00, tmo_ind, tmo_flg}, 8'h03, "timeout raised");
    chk({7'h00, sda_oe}, 8'h00, "line released");
    u_host.stop_cond();
    chk({6'h00, tmo_ind, tmo_flg}, 8'h03, "held until start");
    i2c_wr(ADDR, 8'h11, 8'h00, 8'h00, 1'b0, 1'b1);
    chk({6'h00, tmo_ind, tmo_flg}, 8'h00, "flag cleared");
    // SPI: clock parked low outside frames, chip select on the lower pick pin
    @(negedge clk) i2c_mode_sel = 1'b0;
    pick_lo = 1'b1;
    u_host.park_clock(1'b0);
    repeat (8) @(negedge clk);
    spi_txn({8'h00, 8'h00, 8'h0b}, 2, 1'b1, d0);
    spi_txn({8'h00, 8'h80, 8'hff}, 2, 1'b1, d0);
    chk(d0, {1'b0, TGT}, "three wire read");
    spi_txn({8'h00, 8'h00, 8'h2b}, 2, 1'b1, d0);
    spi_txn({8'h00, 8'h40, 8'h00}, 2, 1'b1, d0);
    chk({7'h00, line_mode}, 8'h00, "back to four wire");
    spi_txn({8'he0, 8'h0b, 8'h55}, 3, 1'b0, d0);
    spi_txn({8'h00, 8'h00, 8'h0b}, 2, 1'b0, d0);
    spi_txn({8'h00, 8'ha0, 8'hff}, 2, 1'b0, d0);
    chk(d0, 8'h55, "four wire read");
    spi_txn({8'h00, 8'h80, 8'hff}, 2, 1'b0, d0);
    chk(d0, 8'h00, "read after increment");
    report_and_stop();
  end
endmodule : tb_serial_host_port_config
